// file: core/nvac_array.sv
`timescale 1ns/100ps
module nvac_array
  import nvac_pkg::*;
#(
  parameter int DEPTH = NVAC_DEPTH
) (
  input wire logic    mclk,
  nvac_array_if.mem   arr
);
  logic [7:0] mem_q [DEPTH];
  // Nonvolatile cells: no reset, contents survive a CPU reset
  always_ff @(posedge mclk) begin
    if (arr.wr) begin
      mem_q[arr.addr] <= arr.wdata;
    end
  end
  assign arr.rdata = mem_q[arr.addr];
endmodule : nvac_array

// file: core/nvac_array_if.sv
`timescale 1ns/100ps
interface nvac_array_if;
  import nvac_pkg::*;
  logic [NVAC_ADDR_W-1:0] addr;
  logic [7:0]             wdata;
  logic [7:0]             rdata;
  logic                   wr;
  modport ctrl (output addr, output wdata, output wr, input rdata);
  modport mem  (input addr, input wdata, input wr, output rdata);
endinterface : nvac_array_if

// file: core/nvac_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - A 9-bit address picks one of 512 bytes, linearly from 0 to 511.
// - Address bits 15..9 and control bits 7..4 always read zero.
// - The data register holds the byte to write, and after a read the byte fetched.
// - With ready enable and global enable set, a level request stands while the strobe is zero.
// - The arm bit clears itself four cycles after software sets it.
// - Setting the write strobe starts a write only while the arm bit is set.
// - No data write may start while flash self-programming is active.
// - The write strobe stays set for the whole write and clears when it is done.
// - Launching a write stalls the CPU for two cycles.
// - A read strobe fetches the byte at once and stalls the CPU for four cycles.
// - During a write, read strobes and address changes are ignored.
// - Each write is timed by 67584 cycles of the calibrated oscillator.
// - A reset during a write clears the strobe; the byte survives only if the array took it, one cycle after launch.
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int WRITE_OSC_CYC = NVAC_WRITE_OSC_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [1:0] reg_sel,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       global_irq_en,
  input  wire logic       selfprog_active,
  input  wire logic       osc_tick,
  output logic      [7:0] reg_rdata,
  output logic            cpu_stall,
  output logic            ready_irq
);
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b01,
    NVAC_WRITE = 2'b10
  } nvac_state_e;

  localparam int CNT_W = $clog2(WRITE_OSC_CYC + 1);
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_OSC_CYC - 1);

  nvac_array_if arr ();

  nvac_state_e             state_q;
  logic [NVAC_ADDR_W-1:0]  addr_q;
  logic [7:0]              data_q;
  logic                    irq_en_q;
  logic                    arm_q;
  logic [2:0]              arm_cnt_q;
  logic [CNT_W-1:0]        wcnt_q;
  logic [2:0]              stall_cnt_q;
  logic                    wr_pulse_q;
  logic [7:0]              rdata_q;
  logic                    stall_q;
  logic                    irq_q;

  wire wr_addr_lo = reg_wr && reg_sel == NVAC_SEL_ADDR_LOW;
  wire wr_addr_hi = reg_wr && reg_sel == NVAC_SEL_ADDR_HIGH;
  wire wr_data    = reg_wr && reg_sel == NVAC_SEL_DATA;
  wire wr_ctrl    = reg_wr && reg_sel == NVAC_SEL_CONTROL;
  wire busy       = state_q == NVAC_WRITE;
  // strobe gated by arm; refuses launch during self-programming
  wire launch     = wr_ctrl && reg_wdata[NVAC_BIT_WRITE_STROBE] && arm_q && !busy
                    && !selfprog_active;
  wire do_read    = wr_ctrl && reg_wdata[NVAC_BIT_READ_STROBE] && !busy && !launch;
  wire arm_set    = wr_ctrl && reg_wdata[NVAC_BIT_ARM] && !reg_wdata[NVAC_BIT_WRITE_STROBE];
  wire write_done = busy && osc_tick && wcnt_q == WRITE_LAST;
  wire [7:0] ctrl_view = {4'h0, irq_en_q, arm_q, busy, 1'b0};
  wire [7:0] rd_mux = (reg_sel == NVAC_SEL_ADDR_LOW)  ? addr_q[7:0] :
                      (reg_sel == NVAC_SEL_ADDR_HIGH) ? {7'h00, addr_q[8]} :
                      (reg_sel == NVAC_SEL_DATA)      ? data_q : ctrl_view;

  assign arr.addr  = addr_q;
  assign arr.wdata = data_q;
  assign arr.wr    = wr_pulse_q;

  nvac_array #(
    .DEPTH (NVAC_DEPTH)
  ) u_array (
    .mclk (mclk),
    .arr  (arr)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= NVAC_ADDR_RESET;
    end else if (wr_addr_lo && !busy) begin
      addr_q[7:0] <= reg_wdata;
    end else if (wr_addr_hi && !busy) begin
      addr_q[8] <= reg_wdata[0];
    end
  end

  // data holds write byte or fetched byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_q <= NVAC_DATA_RESET;
    end else if (do_read) begin
      data_q <= arr.rdata;
    end else if (wr_data && !busy) begin
      data_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= NVAC_CTRL_RESET[NVAC_BIT_IRQ_EN];
    end else if (wr_ctrl) begin
      irq_en_q <= reg_wdata[NVAC_BIT_IRQ_EN];
    end
  end

  // arm window self-clears after four cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_q     <= NVAC_CTRL_RESET[NVAC_BIT_ARM];
      arm_cnt_q <= 3'h0;
    end else if (arm_set) begin
      arm_q     <= 1'b1;
      arm_cnt_q <= 3'(NVAC_ARM_CYCLES - 1);
    end else if (arm_q) begin
      arm_q     <= arm_cnt_q != 3'h0;
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end

  // strobe held for the oscillator-timed write; idle at reset
  // is kept only as far as a reset does not reach: the array write is single-cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= NVAC_IDLE;
      wcnt_q     <= '0;
      wr_pulse_q <= 1'b0;
    end else begin
      wr_pulse_q <= launch;
      unique case (state_q)
        NVAC_IDLE: begin
          if (launch) begin
            state_q <= NVAC_WRITE;
            wcnt_q  <= '0;
          end
        end
        NVAC_WRITE: begin
          if (write_done) begin
            state_q <= NVAC_IDLE;
          end else if (osc_tick) begin
            wcnt_q <= wcnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_q <= 3'h0;
    end else if (launch) begin
      stall_cnt_q <= 3'(NVAC_WSTALL_CYCLES);
    end else if (do_read) begin
      stall_cnt_q <= 3'(NVAC_RSTALL_CYCLES);
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
      stall_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= rd_mux;
      stall_q <= launch || do_read || stall_cnt_q > 3'h1;
      // level request while strobe is low
      irq_q   <= irq_en_q && global_irq_en && !busy;
    end
  end

  assign reg_rdata = rdata_q;
  assign cpu_stall = stall_q;
  assign ready_irq = irq_q;

  // Arm set, then four cycles with no fresh arm request
  sequence arm_seq;
    arm_set ##1 !arm_set [*4];
  endsequence

  arm_timeout_a: assert property (@(posedge mclk) disable iff (!nrst)
    arm_seq |-> arm_q ##1 !arm_q)
    else $error("arm bit did not clear after four cycles");

  launch_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(busy) |-> $past(arm_q) && $past(wr_ctrl)
      && $past(reg_wdata[NVAC_BIT_WRITE_STROBE]) && !$past(selfprog_active))
    else $error("write started without arm");

  write_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    busy && !write_done |=> busy)
    else $error("write strobe dropped early");

  wstall_len_a: assert property (@(posedge mclk) disable iff (!nrst)
    launch |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("write stall not two cycles");

  rstall_len_a: assert property (@(posedge mclk) disable iff (!nrst)
    do_read |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");

  read_fetch_a: assert property (@(posedge mclk) disable iff (!nrst)
    do_read |=> data_q == $past(arr.rdata))
    else $error("read did not fetch byte");

  addr_frozen_a: assert property (@(posedge mclk) disable iff (!nrst)
    busy && $past(busy) |-> $stable(addr_q))
    else $error("address changed during write");

  irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
    irq_en_q && global_irq_en && !busy |=> ready_irq)
    else $error("ready request missing");

  resv_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    $past(reg_sel) == NVAC_SEL_ADDR_HIGH |-> reg_rdata[7:1] == 7'h00)
    else $error("reserved address bits not zero");
endmodule : nvac_ctrl

// file: core/nvac_pkg.sv
package nvac_pkg;
  // Register selectors on the CPU register port
  localparam logic [1:0] NVAC_SEL_ADDR_LOW  = 2'h0;
  localparam logic [1:0] NVAC_SEL_ADDR_HIGH = 2'h1;
  localparam logic [1:0] NVAC_SEL_DATA      = 2'h2;
  localparam logic [1:0] NVAC_SEL_CONTROL   = 2'h3;
  // Control register fields
  localparam int NVAC_BIT_READ_STROBE  = 0;
  localparam int NVAC_BIT_WRITE_STROBE = 1;
  localparam int NVAC_BIT_ARM          = 2;
  localparam int NVAC_BIT_IRQ_EN       = 3;
  // Array geometry
  localparam int NVAC_ADDR_W = 9;
  localparam int NVAC_DEPTH  = 512;
  // Timing and reset values
  localparam int NVAC_ARM_CYCLES     = 4;
  localparam int NVAC_WSTALL_CYCLES  = 2;
  localparam int NVAC_RSTALL_CYCLES  = 4;
  localparam int NVAC_WRITE_OSC_CYC  = 67584;
  localparam logic [7:0] NVAC_CTRL_RESET = 8'h00;
  localparam logic [7:0] NVAC_DATA_RESET = 8'h00;
  localparam logic [8:0] NVAC_ADDR_RESET = 9'h000;
endpackage : nvac_pkg

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import nvac_pkg::*;
  localparam int OSC_N = 8;
  logic       mclk;
  logic       nrst;
  logic [1:0] reg_sel;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       global_irq_en;
  logic       selfprog_active;
  logic       osc_tick;
  logic [7:0] reg_rdata;
  logic       cpu_stall;
  logic       ready_irq;
  logic [7:0] d;
  int         miscompares;
  int         n_tests;

  // Short write time keeps the run brief
  nvac_ctrl #(.WRITE_OSC_CYC(OSC_N)) i_nvac_ctrl (
    .mclk            (mclk),
    .nrst            (nrst),
    .reg_sel         (reg_sel),
    .reg_wr          (reg_wr),
    .reg_wdata       (reg_wdata),
    .global_irq_en   (global_irq_en),
    .selfprog_active (selfprog_active),
    .osc_tick        (osc_tick),
    .reg_rdata       (reg_rdata),
    .cpu_stall       (cpu_stall),
    .ready_irq       (ready_irq)
  );

  always #50 mclk = ~mclk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    @(negedge mclk);
    reg_sel   = sel;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  // Readback lags the select by one cycle
  task automatic rd(input logic [1:0] sel, output logic [7:0] v);
    @(negedge mclk);
    reg_sel = sel;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd

  task automatic stall_cnt(input string what, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8) begin
      if (cpu_stall === 1'b1) n = n + 8'h01;
      @(negedge mclk);
    end
    chk(what, exp, n);
  endtask : stall_cnt

  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge mclk);
      osc_tick = 1'b1;
      @(negedge mclk);
      osc_tick = 1'b0;
    end
  endtask : ticks

  task automatic t_reset_reserved();
    rd(NVAC_SEL_CONTROL, d);
    chk("ctrl_reset", 8'h00, d);
    wr(NVAC_SEL_ADDR_HIGH, 8'hff);
    rd(NVAC_SEL_ADDR_HIGH, d);
    chk("addr_high", 8'h01, d);
    wr(NVAC_SEL_ADDR_LOW, 8'ha5);
    wr(NVAC_SEL_CONTROL, 8'hf8);
    rd(NVAC_SEL_CONTROL, d);
    chk("ctrl_reserved", 8'h08, d);
    chk("irq_on", 8'h01, {7'h00, ready_irq});
    global_irq_en = 1'b0;
    repeat (2) @(negedge mclk);
    chk("irq_global_off", 8'h00, {7'h00, ready_irq});
    global_irq_en = 1'b1;
    wr(NVAC_SEL_CONTROL, 8'h00);
    @(negedge mclk);
    chk("irq_off", 8'h00, {7'h00, ready_irq});
  endtask : t_reset_reserved

  task automatic t_write_read();
    wr(NVAC_SEL_DATA, 8'h3c);
    global_irq_en = 1'b0;
    wr(NVAC_SEL_CONTROL, 8'h0c);
    wr(NVAC_SEL_CONTROL, 8'h0a);
    global_irq_en = 1'b1;
    stall_cnt("write_stall", 8'h02);
    chk("irq_busy", 8'h00, {7'h00, ready_irq});
    rd(NVAC_SEL_CONTROL, d);
    chk("busy_ctrl", 8'h0a, d);
    wr(NVAC_SEL_ADDR_LOW, 8'h00);
    // Read strobe while busy must not stall
    wr(NVAC_SEL_CONTROL, 8'h09);
    stall_cnt("busy_read_stall", 8'h00);
    ticks(OSC_N - 1);
    rd(NVAC_SEL_CONTROL, d);
    chk("still_busy", 8'h0a, d);
    ticks(1);
    repeat (2) @(negedge mclk);
    rd(NVAC_SEL_CONTROL, d);
    chk("write_done", 8'h08, d);
    chk("irq_ready", 8'h01, {7'h00, ready_irq});
    wr(NVAC_SEL_DATA, 8'h00);
    wr(NVAC_SEL_CONTROL, 8'h09);
    stall_cnt("read_stall", 8'h04);
    rd(NVAC_SEL_DATA, d);
    chk("read_data", 8'h3c, d);
    rd(NVAC_SEL_ADDR_LOW, d);
    chk("addr_kept", 8'ha5, d);
  endtask : t_write_read

  task automatic t_arm_rules();
    wr(NVAC_SEL_CONTROL, 8'h04);
    rd(NVAC_SEL_CONTROL, d);
    chk("arm_set", 8'h04, d);
    repeat (4) @(negedge mclk);
    rd(NVAC_SEL_CONTROL, d);
    chk("arm_clear", 8'h00, d);
    wr(NVAC_SEL_CONTROL, 8'h02);
    rd(NVAC_SEL_CONTROL, d);
    chk("late_strobe", 8'h00, d);
    selfprog_active = 1'b1;
    wr(NVAC_SEL_CONTROL, 8'h04);
    wr(NVAC_SEL_CONTROL, 8'h02);
    rd(NVAC_SEL_CONTROL, d);
    chk("selfprog_block", 8'h00, d & 8'h02);
    selfprog_active = 1'b0;
  endtask : t_arm_rules

  // Reset lands half a cycle after the array took the byte
  task automatic t_reset_midwrite();
    wr(NVAC_SEL_ADDR_LOW, 8'h5a);
    wr(NVAC_SEL_DATA, 8'hc3);
    wr(NVAC_SEL_CONTROL, 8'h04);
    wr(NVAC_SEL_CONTROL, 8'h02);
    @(negedge mclk);
    nrst = 1'b0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    rd(NVAC_SEL_CONTROL, d);
    chk("reset_ctrl", 8'h00, d);
    wr(NVAC_SEL_ADDR_HIGH, 8'h01);
    wr(NVAC_SEL_ADDR_LOW, 8'h5a);
    wr(NVAC_SEL_CONTROL, 8'h01);
    rd(NVAC_SEL_DATA, d);
    chk("reset_write_kept", 8'hc3, d);
  endtask : t_reset_midwrite

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    mclk = 1'b0; nrst = 1'b0; reg_sel = 2'h0; reg_wr = 1'b0; reg_wdata = 8'h00;
    global_irq_en = 1'b1; selfprog_active = 1'b0; osc_tick = 1'b0;
    miscompares = 0; n_tests = 0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    t_reset_reserved();
    t_write_read();
    t_arm_rules();
    t_reset_midwrite();
    final_report();
  end

  // Whole sequence needs well under two hundred cycles
  initial begin
    #(3000 * 100);
    miscompares++;
    final_report();
  end
endmodule : testbench
